// File: include/rig_params.svh
// Offsets, field positions, reset values and vectors of the reset initialisation group
// Operation
// - Three classes: power-on, system resets, wake-up; each loads its own contents.
// - Interrupt wake with either global enable set loads the matching vector, unless a stack overflow reset takes over.
// - Such a wake pushes the current program counter into the return top registers unless the stack is full.
// - Such a wake advances the return stack pointer to the next stack slot unless the stack is full.
// - An interrupt wake-up leaves cause flags set in the interrupt flag registers.
// - Port A bits 6 and 7 exist only when the oscillator mode frees them.
// - Disabled port A bits 6 and 7 are not driven and read zero.
// - Unimplemented bits read zero; unchanged bits hold; unknown bits need no value.
// - Conditional bits take values from reset cause or oscillator state.
// - Stack overflow with reset enabled clears the program counter and sets stack full.
`ifndef RIG_PARAMS_SVH
`define RIG_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define RIG_IDX_P1H     0
`define RIG_IDX_P1L     1
`define RIG_IDX_BANK    2
`define RIG_IDX_P2H     3
`define RIG_IDX_P2L     4
`define RIG_IDX_ALU     5
`define RIG_IDX_T0H     6
`define RIG_IDX_T0L     7
`define RIG_IDX_T0CTL   8
`define RIG_IDX_OSC     9
`define RIG_IDX_HLVD    10
`define RIG_IDX_WDT     11
`define RIG_IDX_RCAUSE  12
`define RIG_IDX_T1H     13
`define RIG_IDX_T1L     14
`define RIG_IDX_T1CTL   15
`define RIG_IDX_T2      16
`define RIG_IDX_T2PER   17
`define RIG_IDX_T2CTL   18
`define RIG_IDX_SBUF    19
`define RIG_IDX_SADD    20
`define RIG_IDX_SSTAT   21
`define RIG_IDX_SCON1   22
`define RIG_IDX_SCON2   23
`define RIG_IDX_PCL     24
`define RIG_IDX_PCH     25
`define RIG_IDX_PCU     26
`define RIG_IDX_RET_LO  27
`define RIG_IDX_RET_HI  28
`define RIG_IDX_RET_UP  29
`define RIG_IDX_SP      30
`define RIG_IDX_INTCON  31
`define RIG_IDX_PIR     32
`define RIG_IDX_PA_LAT  33
`define RIG_IDX_PA_DIR  34
`define RIG_IDX_PA_PIN  35
`define RIG_IDX_CFG     36
`define RIG_NREG        37

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define RIG_CFG_OVFRST   0
`define RIG_CFG_PAFREE   1
`define RIG_INT_EN_HIGH  7
`define RIG_INT_EN_LOW   6
`define RIG_SP_FULL      7
`define RIG_SP_TOP       5'h1F
`define RIG_RC_RI        4
`define RIG_RC_TO        3
`define RIG_RC_PD        2
`define RIG_OSC_STABLE   3
`define RIG_OSC_WAKEQ    1
`define RIG_RCAUSE_POR   8'h1C
`define RIG_VEC_HIGH     21'h000018
`define RIG_VEC_LOW      21'h000008
`define RIG_PC_STEP      21'h000002
`define RIG_PA_FREE_MASK 8'hFF
`define RIG_PA_PIN_MASK  8'h3F

`endif

// File: include/rig_pkg.sv
// Types shared by the reset initialisation group
package rig_pkg;
    // Initialisation class applied in one cycle
    typedef enum logic [2:0] {
        RIG_CLS_NONE,
        RIG_CLS_POWER,
        RIG_CLS_SYSTEM,
        RIG_CLS_STACK,
        RIG_CLS_WAKE
    } rig_class_t;
endpackage

// File: rtl/rig_reset_init.sv
// Reset initialisation register group with an Avalon-MM slave port
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`include "rig_params.svh"

module rig_reset_init
    import rig_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        por_event,
    input  wire logic        system_reset_event,
    input  wire logic        reset_instr_event,
    input  wire logic        wdt_reset_event,
    input  wire logic        wdt_wake_event,
    input  wire logic        int_wake_event,
    input  wire logic        int_wake_high,
    input  wire logic [7:0]  wake_flags,
    input  wire logic        osc_stable,
    input  wire logic [7:0]  port_a_pins,
    output logic      [7:0]  port_a_out,
    output logic      [7:0]  port_a_oe,
    output logic      [20:0] program_counter
);

    // ----------------------------------------------------------------
    // Register table: {implemented mask, power-on value, kept on system reset}
    // ----------------------------------------------------------------
    function automatic logic [23:0] rig_table(input int idx);
        case (idx)
            `RIG_IDX_P1H, `RIG_IDX_BANK, `RIG_IDX_P2H: rig_table = {8'h0F, 8'h00, 8'h00};
            `RIG_IDX_P1L, `RIG_IDX_P2L, `RIG_IDX_T0L,
            `RIG_IDX_T1H, `RIG_IDX_T1L, `RIG_IDX_SBUF: rig_table = {8'hFF, 8'h00, 8'hFF};
            `RIG_IDX_ALU:    rig_table = {8'h1F, 8'h00, 8'h1F};
            `RIG_IDX_T0CTL:  rig_table = {8'hFF, 8'hFF, 8'h00};
            `RIG_IDX_OSC:    rig_table = {8'hFF, 8'h40, 8'h00};
            `RIG_IDX_HLVD:   rig_table = {8'hBF, 8'h05, 8'h00};
            `RIG_IDX_WDT:    rig_table = {8'h01, 8'h00, 8'h00};
            `RIG_IDX_RCAUSE: rig_table = {8'hDF, `RIG_RCAUSE_POR, 8'h5F};
            `RIG_IDX_T1CTL:  rig_table = {8'hFF, 8'h00, 8'hBF};
            `RIG_IDX_T2PER:  rig_table = {8'hFF, 8'hFF, 8'h00};
            `RIG_IDX_T2CTL:  rig_table = {8'h7F, 8'h00, 8'h00};
            `RIG_IDX_PCU, `RIG_IDX_RET_UP: rig_table = {8'h1F, 8'h00, 8'h00};
            `RIG_IDX_SP:     rig_table = {8'hDF, 8'h00, 8'hC0};
            `RIG_IDX_INTCON: rig_table = {8'hFF, 8'h00, 8'h01};
            `RIG_IDX_PA_DIR: rig_table = {8'hFF, 8'hFF, 8'h00};
            `RIG_IDX_CFG:    rig_table = {8'h03, 8'h00, 8'h03};
            default:         rig_table = {8'hFF, 8'h00, 8'h00};
        endcase
    endfunction

    logic [7:0] regs      [0:`RIG_NREG-1];
    logic [7:0] next_regs [0:`RIG_NREG-1];

    // ----------------------------------------------------------------
    // Class decode and derived state
    // ----------------------------------------------------------------
    // Power-on beats system resets, which beat the stack reset and wake-ups
    wire        any_sys    = system_reset_event | reset_instr_event | wdt_reset_event;
    wire        gie_any    = regs[`RIG_IDX_INTCON][`RIG_INT_EN_HIGH] | regs[`RIG_IDX_INTCON][`RIG_INT_EN_LOW];
    wire        vec_ok     = int_wake_event & gie_any;
    wire        stack_full = regs[`RIG_IDX_SP][4:0] == `RIG_SP_TOP;
    wire        ovf_rst_en = regs[`RIG_IDX_CFG][`RIG_CFG_OVFRST];
    wire        do_stack   = vec_ok & stack_full & ovf_rst_en;
    wire        do_wake    = wdt_wake_event | int_wake_event;
    wire        push_ok    = vec_ok & ~stack_full;
    wire        overflow   = vec_ok & stack_full & ~ovf_rst_en;
    rig_class_t cls;
    assign cls = por_event ? RIG_CLS_POWER :
                 any_sys   ? RIG_CLS_SYSTEM :
                 do_stack  ? RIG_CLS_STACK :
                 do_wake   ? RIG_CLS_WAKE : RIG_CLS_NONE;

    wire [20:0] pc_cur  = {regs[`RIG_IDX_PCU][4:0], regs[`RIG_IDX_PCH], regs[`RIG_IDX_PCL]};
    wire [20:0] pc_vec  = int_wake_high ? `RIG_VEC_HIGH : `RIG_VEC_LOW;
    // Without an enabled vector the core simply resumes at the next word
    // An enabled vector is taken when a full stack blocks the push only if the overflow reset is off
    wire [20:0] pc_wake = vec_ok ? pc_vec : 21'(pc_cur + `RIG_PC_STEP);
    wire [4:0]  sp_inc  = 5'(regs[`RIG_IDX_SP][4:0] + 5'h01);
    // Bits 6 and 7 of port A vanish unless the oscillator mode frees them
    wire [7:0]  pa_mask = regs[`RIG_IDX_CFG][`RIG_CFG_PAFREE] ? `RIG_PA_FREE_MASK : `RIG_PA_PIN_MASK;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire [5:0]  widx     = avs_address[7:2];
    wire        mapped   = widx < 6'(`RIG_NREG);
    wire        wr_hit   = avs_write & ~avs_waitrequest & mapped;
    wire [23:0] rd_tbl   = rig_table(int'(widx));
    wire        pa_reg   = widx == 6'(`RIG_IDX_PA_LAT) || widx == 6'(`RIG_IDX_PA_DIR);
    // Port A pins are read live; unmapped words read zero
    wire [7:0]  rd_byte  = !mapped                        ? 8'h00 :
                           widx == 6'(`RIG_IDX_PA_PIN)    ? port_a_pins & pa_mask :
                           pa_reg                         ? regs[widx] & pa_mask :
                                                            regs[widx] & rd_tbl[23:16];

    // ----------------------------------------------------------------
    // Next register values: bus write first, then class loads on top
    // ----------------------------------------------------------------
    // A hardware load in the same cycle as a write wins, so no event is lost
    always_comb begin
        logic [23:0] t;
        logic [7:0]  n;
        t = 24'h000000;
        n = 8'h00;
        for (int i = 0; i < `RIG_NREG; i++) begin
            t = rig_table(i);
            n = regs[i];
            if (wr_hit && int'(widx) == i && i != `RIG_IDX_PA_PIN) begin
                n = avs_writedata[7:0] & t[23:16];
            end
            case (cls)
                RIG_CLS_POWER: begin
                    n = t[15:8] & t[23:16];
                end
                RIG_CLS_SYSTEM, RIG_CLS_STACK: begin
                    n = ((regs[i] & t[7:0]) | (t[15:8] & ~t[7:0])) & t[23:16];
                end
                RIG_CLS_WAKE: begin
                    if (i == `RIG_IDX_T2PER) begin
                        n = 8'hFF;
                    end
                end
                default: ;
            endcase
            // Oscillator state bit is conditional on the clock being ready
            if (i == `RIG_IDX_OSC) begin
                if (cls == RIG_CLS_POWER || cls == RIG_CLS_SYSTEM || cls == RIG_CLS_STACK) begin
                    n[`RIG_OSC_STABLE] = osc_stable;
                end else if (cls == RIG_CLS_WAKE) begin
                    n[`RIG_OSC_WAKEQ] = osc_stable;
                end
            end
            // Reset cause flags follow whichever event fired
            if (i == `RIG_IDX_RCAUSE) begin
                if (cls == RIG_CLS_SYSTEM) begin
                    n[`RIG_RC_PD] = 1'b1;
                    if (reset_instr_event) n[`RIG_RC_RI] = 1'b0;
                    if (wdt_reset_event) n[`RIG_RC_TO] = 1'b0;
                end else if (cls == RIG_CLS_WAKE) begin
                    n[`RIG_RC_PD] = 1'b0;
                    if (wdt_wake_event) n[`RIG_RC_TO] = 1'b0;
                end
            end
            // Stack overflow: full flag set; pointer kept on a wake, cleared by the stack reset
            if (i == `RIG_IDX_SP) begin
                if (cls == RIG_CLS_STACK || (cls == RIG_CLS_WAKE && overflow)) begin
                    n[`RIG_SP_FULL] = 1'b1;
                end else if (cls == RIG_CLS_WAKE && push_ok) begin
                    n[4:0] = sp_inc;
                end
            end
            // Program counter and pushed return address on wake-up
            if (cls == RIG_CLS_WAKE) begin
                if (i == `RIG_IDX_PCL) n = pc_wake[7:0];
                if (i == `RIG_IDX_PCH) n = pc_wake[15:8];
                if (i == `RIG_IDX_PCU) n = {3'b000, pc_wake[20:16]};
                if (push_ok && i == `RIG_IDX_RET_LO) n = pc_cur[7:0];
                if (push_ok && i == `RIG_IDX_RET_HI) n = pc_cur[15:8];
                if (push_ok && i == `RIG_IDX_RET_UP) n = {3'b000, pc_cur[20:16]};
                if (int_wake_event && i == `RIG_IDX_PIR) n = regs[i] | wake_flags;
            end
            next_regs[i] = n;
        end
    end

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    // Reset only loads constants from the table
    always_ff @(posedge clock) begin
        for (int i = 0; i < `RIG_NREG; i++) begin
            if (!rst_n) begin
                regs[i] <= 8'(rig_table(i) >> 8);
            end else if (ce) begin
                regs[i] <= next_regs[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus slave: one wait cycle, then the answer
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else if (ce) begin
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                avs_readdata    <= avs_read ? {24'h000000, rd_byte} : 32'h00000000;
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin and program counter outputs
    // ----------------------------------------------------------------
    // Latch bit 1 in direction means input, so the enable is its inverse
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            port_a_out      <= 8'h00;
            port_a_oe       <= 8'h00;
            program_counter <= 21'h000000;
        end else if (ce) begin
            port_a_out      <= next_regs[`RIG_IDX_PA_LAT] & pa_mask;
            port_a_oe       <= ~next_regs[`RIG_IDX_PA_DIR] & pa_mask;
            program_counter <= {next_regs[`RIG_IDX_PCU][4:0], next_regs[`RIG_IDX_PCH],
                                next_regs[`RIG_IDX_PCL]};
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n || !ce);

    sequence s_vec_wake;
        ce && cls == RIG_CLS_WAKE && push_ok;
    endsequence
    sequence s_read_hlvd;
        ce && avs_read && avs_waitrequest && widx == 6'(`RIG_IDX_HLVD);
    endsequence

    property p_class_differs;
        ce && cls == RIG_CLS_SYSTEM |=> regs[`RIG_IDX_T0L] == $past(regs[`RIG_IDX_T0L])
                                        && regs[`RIG_IDX_T0H] == 8'h00;
    endproperty
    a_class_differs: assert property (p_class_differs) else $error("system reset load wrong");

    property p_vector;
        s_vec_wake |=> program_counter == $past(pc_vec);
    endproperty
    a_vector: assert property (p_vector) else $error("wake vector not loaded");

    property p_push;
        s_vec_wake |=> {regs[`RIG_IDX_RET_UP][4:0], regs[`RIG_IDX_RET_HI], regs[`RIG_IDX_RET_LO]} == $past(pc_cur);
    endproperty
    a_push: assert property (p_push) else $error("return address not pushed");

    property p_sp_step;
        s_vec_wake |=> regs[`RIG_IDX_SP][4:0] == 5'($past(regs[`RIG_IDX_SP][4:0]) + 5'h01);
    endproperty
    a_sp_step: assert property (p_sp_step) else $error("stack pointer not advanced");

    property p_wake_flags;
        ce && cls == RIG_CLS_WAKE && int_wake_event |=>
            (regs[`RIG_IDX_PIR] & $past(wake_flags)) == $past(wake_flags);
    endproperty
    a_wake_flags: assert property (p_wake_flags) else $error("wake cause flag missing");

    property p_pa_hidden;
        !regs[`RIG_IDX_CFG][`RIG_CFG_PAFREE] && $stable(regs[`RIG_IDX_CFG]) |=>
            port_a_oe[7:6] == 2'b00 && port_a_out[7:6] == 2'b00;
    endproperty
    a_pa_hidden: assert property (p_pa_hidden) else $error("hidden port bits driven");

    property p_unimpl_zero;
        s_read_hlvd |=> !avs_waitrequest && avs_readdata[31:8] == 24'h000000 && !avs_readdata[6];
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit not zero");

    property p_osc_cond;
        ce && cls == RIG_CLS_POWER |=> regs[`RIG_IDX_OSC] == {4'h4, $past(osc_stable), 3'b000};
    endproperty
    a_osc_cond: assert property (p_osc_cond) else $error("oscillator state bit wrong");

    property p_stack_reset;
        ce && cls == RIG_CLS_STACK |=> program_counter == 21'h000000 && regs[`RIG_IDX_SP][`RIG_SP_FULL];
    endproperty
    a_stack_reset: assert property (p_stack_reset) else $error("stack reset incomplete");

    property p_period_ones;
        ce && cls != RIG_CLS_NONE |=> regs[`RIG_IDX_T2PER] == 8'hFF;
    endproperty
    a_period_ones: assert property (p_period_ones) else $error("period register not all ones");

endmodule

// File: bench/reset_init_register_group_test.sv
// Self-checking testbench for the reset initialisation register group
`include "rig_params.svh"

module reset_init_register_group_test import rig_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Signals and register table
    // ----------------------------------------------------------------
    logic        clock;
    logic        rst_n;
    logic        ce;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [5:0]  ev;
    logic        int_wake_high;
    logic [7:0]  wake_flags;
    logic        osc_stable;
    logic [7:0]  port_a_pins;
    logic [7:0]  port_a_out;
    logic [7:0]  port_a_oe;
    logic [20:0] program_counter;
    int          err_count;
    int          checks_done;

    // Index, power-on value, writable mask, system class code (0 load, 1 hold, 2 bit6 clear, 3 skip, 4 osc)
    localparam int         NT = 22;
    localparam int         IDX [NT] = '{0, 1, 2, 3, 4, 5, 6, 8, 11, 15, 16, 17, 18, 19, 20, 22, 23, 33, 34, 9, 10, 21};
    localparam logic [7:0] RV [NT]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00,
                                        8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h40, 8'h05, 8'h00};
    localparam logic [7:0] MSK [NT] = '{8'h0F, 8'hFF, 8'h0F, 8'h0F, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'h01, 8'hFF, 8'hFF,
                                        8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h00, 8'h00, 8'h00};
    localparam int         SYS [NT] = '{0, 1, 0, 0, 1, 1, 0, 0, 0, 2, 0, 0, 0, 1, 0, 0, 0, 3, 3, 4, 0, 0};

    rig_reset_init dut (
        .clock              (clock),
        .rst_n              (rst_n),
        .ce                 (ce),
        .avs_address        (avs_address),
        .avs_read           (avs_read),
        .avs_write          (avs_write),
        .avs_writedata      (avs_writedata),
        .avs_readdata       (avs_readdata),
        .avs_waitrequest    (avs_waitrequest),
        .por_event          (ev[0]),
        .system_reset_event (ev[1]),
        .reset_instr_event  (ev[2]),
        .wdt_reset_event    (ev[3]),
        .wdt_wake_event     (ev[4]),
        .int_wake_event     (ev[5]),
        .int_wake_high      (int_wake_high),
        .wake_flags         (wake_flags),
        .osc_stable         (osc_stable),
        .port_a_pins        (port_a_pins),
        .port_a_out         (port_a_out),
        .port_a_oe          (port_a_oe),
        .program_counter    (program_counter)
    );

    // 50 ns period
    always #25 clock = ~clock;

    // ----------------------------------------------------------------
    // Expectations and bus tasks
    // ----------------------------------------------------------------
    // Value a register should hold after an event of class cls
    function automatic logic [7:0] exp_val(int cls, int i, logic [7:0] held, logic osc);
        if (cls == 0)
            return (IDX[i] == 9) ? {4'h4, osc, 3'h0} : RV[i];
        if (cls >= 4)
            return (IDX[i] == 17) ? 8'hFF : held;
        case (SYS[i])
            0: return RV[i];
            2: return held & 8'hBF;
            4: return {4'h4, osc, 3'h0};
            default: return held;
        endcase
    endfunction

    task automatic stop_test();
        if (err_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One Avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic wr, input int idx, input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge clock);
        avs_address <= 8'(idx * 4);
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, d};
        for (n = 0; n < 16; n++) begin
            @(posedge clock);
            if (avs_waitrequest === 1'b0)
                break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n == 16) begin
            err_count++;
            stop_test();
        end
    endtask

    task automatic wr(input int idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rd_chk(input int idx, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(q, {24'h0, e});
    endtask

    // Event pulse one cycle long; a third edge lets registered outputs settle before a look
    task automatic pulse(input int k);
        @(posedge clock);
        ev <= 6'(1 << k);
        @(posedge clock);
        ev <= 6'h00;
        @(posedge clock);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] q;
        logic [7:0]  sh [NT];
        logic [7:0]  v;
        logic [7:0]  e;
        logic [7:0]  m;
        logic [7:0]  lo;
        logic [7:0]  hi;
        logic [7:0]  up;
        logic [20:0] pc0;
        clock = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        ev = 6'h00;
        int_wake_high = 1'b0;
        wake_flags = 8'h00;
        osc_stable = 1'b0;
        port_a_pins = 8'h00;
        err_count = 0;
        checks_done = 0;
        void'($urandom(32'h1BA7AA38));
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < NT; i++) begin
            rd_chk(IDX[i], RV[i]);
            sh[i] = RV[i];
        end
        // Each event in turn, with fresh random contents before it
        for (int k = 0; k < 6; k++) begin
            for (int i = 0; i < NT; i++) begin
                if (MSK[i] != 8'h00) begin
                    v = 8'($urandom) & MSK[i];
                    wr(IDX[i], v);
                    rd_chk(IDX[i], v);
                    sh[i] = v;
                end
            end
            osc_stable <= 1'($urandom);
            wake_flags <= 8'($urandom) | 8'h01;
            @(posedge clock);
            pc0 = program_counter;
            pulse(k);
            for (int i = 0; i < NT; i++) begin
                if (!((SYS[i] == 3 && k != 0) || (k >= 4 && IDX[i] == 9))) begin
                    e = exp_val(k, i, sh[i], osc_stable);
                    rd_chk(IDX[i], e);
                    sh[i] = e;
                end
            end
            case (k)
                0: m = 8'hFF;
                1: m = 8'h04;
                2: m = 8'h14;
                default: m = 8'h0C;
            endcase
            bus(1'b0, 12, 8'h00, q);
            chk(q & {24'h0, m}, (k == 0) ? 32'h1C : (k >= 4) ? 32'h0 : 32'h4);
            if (k >= 4)
                chk({11'h0, program_counter}, {11'h0, pc0 + 21'd2});
            if (k == 5) begin
                bus(1'b0, 32, 8'h00, q);
                chk(q & {24'h0, wake_flags}, {24'h0, wake_flags});
            end
        end
        // Interrupt wake with low then high global enable
        for (int h = 0; h < 2; h++) begin
            wr(31, (h == 1) ? 8'h80 : 8'h40);
            lo = 8'($urandom) & 8'hFE;
            hi = 8'($urandom);
            up = 8'($urandom) & 8'h1F;
            wr(24, lo);
            wr(25, hi);
            wr(26, up);
            bus(1'b0, 30, 8'h00, q);
            int_wake_high <= 1'(h);
            pulse(5);
            chk({11'h0, program_counter}, (h == 1) ? 32'h18 : 32'h08);
            rd_chk(27, lo);
            rd_chk(28, hi);
            rd_chk(29, up);
            rd_chk(30, {q[7:6], 1'b0, q[4:0] + 5'd1});
        end
        // Full stack, with and without overflow reset
        for (int s = 0; s < 2; s++) begin
            wr(36, 8'(s));
            wr(31, 8'h80);
            wr(30, 8'h1F);
            pulse(5);
            chk({11'h0, program_counter}, (s == 1) ? 32'h0 : 32'h18);
            rd_chk(30, (s == 1) ? 8'h80 : 8'h9F);
        end
        // Port A upper bits follow the free-pin setting; pins are read-only
        for (int s = 0; s < 2; s++) begin
            m = (s == 1) ? 8'hFF : 8'h3F;
            v = 8'($urandom);
            port_a_pins <= v;
            wr(36, (s == 1) ? 8'h02 : 8'h00);
            wr(33, 8'hFF);
            wr(34, 8'h00);
            wr(35, ~v);
            @(posedge clock);
            chk({24'h0, port_a_out}, {24'h0, m});
            chk({24'h0, port_a_oe}, {24'h0, m});
            rd_chk(35, v & m);
            rd_chk(33, m);
        end
        // Clock enable low freezes state, so a system reset then changes nothing
        wr(6, 8'h5A);
        ce <= 1'b0;
        pulse(1);
        ce <= 1'b1;
        rd_chk(6, 8'h5A);
        // Unmapped place ignores writes and reads zero
        wr(40, 8'h5A);
        rd_chk(40, 8'h00);
        stop_test();
    end
endmodule
